// ==== ecs_sequencer.v ====
`timescale 1ns/100ps
`include "ecs_regs.vh"
module ecs_sequencer #(
   parameter AW = 32
) (
   input  wire          clk,
   input  wire          rst,
   input  wire [AW-1:0] fetch_addr,
   output reg  [AW-1:0] ibus_addr_r,
   output reg           ibus_read_r,
   input  wire          ibus_waitrequest,
   input  wire [31:0]   ibus_readdata,
   output reg  [31:0]   instr_r,
   input  wire [2:0]    op_class,
   input  wire [4:0]    shift_amt,
   input  wire          op_illegal,
   input  wire          irq,
   input  wire [AW-1:0] data_addr,
   input  wire [31:0]   data_wdata,
   output reg  [AW-1:0] dbus_addr_r,
   output reg           dbus_read_r,
   output reg           dbus_write_r,
   output reg  [31:0]   dbus_writedata_r,
   input  wire          dbus_waitrequest,
   output reg           exc_r,
   output reg  [1:0]    exc_cause_r,
   output reg           retire_r,
   output reg           shift_step_r,
   input  wire          dbg_halt,
   output reg           dbg_halted_r
);
   localparam [5:0] S_FETCH = 6'b000001;
   localparam [5:0] S_DEC   = 6'b000010;
   localparam [5:0] S_XFER  = 6'b000100;
   localparam [5:0] S_EXEC  = 6'b001000;
   localparam [5:0] S_SHIFT = 6'b010000;
   localparam [5:0] S_HALT  = 6'b100000;

   reg  [5:0] state_r;
   reg  [5:0] state_nxt;
   reg  [4:0] shcnt_r;
   reg  [5:0] budget;
   reg        cnt_load;
   reg        cnt_run;
   reg        is_mem;
   reg        is_load;
   wire       cnt_done;
   // Handshake terms shared by the state machine and the port registers
   wire       fetch_ok;
   wire       xfer_ok;
   wire       mem_go;

   // Fetch uses 1 cycle, decode 1, the rest of the class budget goes in EXEC.
   always @* begin
      case (op_class)
         `ECS_CLS_LDH: budget = `ECS_CYC_LDH - 6'h02;
         `ECS_CLS_LDB: budget = `ECS_CYC_LDB - 6'h02;
         `ECS_CLS_SHIFT: budget = `ECS_CYC_SHIFT - 6'h02;
         default: budget = `ECS_CYC_BASE - 6'h02;
      endcase
      is_load = (op_class == `ECS_CLS_LDW) || (op_class == `ECS_CLS_LDH)
                || (op_class == `ECS_CLS_LDB);
      is_mem = is_load || (op_class == `ECS_CLS_STORE);
   end

   // A quiet slave is no answer: after reset the request is still low for one cycle
   assign fetch_ok = ibus_read_r && !ibus_waitrequest;
   assign xfer_ok  = (dbus_read_r || dbus_write_r) && !dbus_waitrequest;
   // A pending interrupt or an illegal opcode stops the data transfer before it starts
   assign mem_go   = is_mem && !op_illegal && !irq;

   ecs_cycle_counter #(
      .W (6)
   ) u_cnt (
      .clk   (clk),
      .rst   (rst),
      .load  (cnt_load),
      .count (budget),
      .run   (cnt_run),
      .done  (cnt_done)
   );

   always @* begin
      state_nxt = state_r;
      cnt_load = 1'b0;
      cnt_run = 1'b0;
      case (state_r)
         S_FETCH: begin
            // Wait states hold here, stretching the instruction one for one
            if (fetch_ok)
               state_nxt = S_DEC;
         end
         S_DEC: begin
            cnt_load = 1'b1;
            if (mem_go)
               state_nxt = S_XFER;
            else
               state_nxt = S_EXEC;
         end
         S_XFER: begin
            if (xfer_ok)
               state_nxt = S_EXEC;
         end
         S_EXEC: begin
            cnt_run = 1'b1;
            if (cnt_done) begin
               // A shift that raised an exception retires without shifting
               if (op_class == `ECS_CLS_SHIFT && shcnt_r != 5'h00 && !exc_r)
                  state_nxt = S_SHIFT;
               else
                  state_nxt = dbg_halt ? S_HALT : S_FETCH;
            end
         end
         S_SHIFT: begin
            if (shcnt_r == 5'h01)
               state_nxt = dbg_halt ? S_HALT : S_FETCH;
         end
         S_HALT: begin
            // Halt only between instructions; no breakpoint or trace logic
            if (!dbg_halt)
               state_nxt = S_FETCH;
         end
         default: state_nxt = S_FETCH;
      endcase
   end

   // Sequencer state, the one-cycle status pulses and the halted flag
   always @(posedge clk) begin
      if (rst) begin
         state_r <= S_FETCH;
         shcnt_r <= 5'h00;
         retire_r <= 1'b0;
         shift_step_r <= 1'b0;
         dbg_halted_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         retire_r <= 1'b0;
         shift_step_r <= 1'b0;
         dbg_halted_r <= (state_nxt == S_HALT);
         if (state_r == S_DEC)
            shcnt_r <= shift_amt;
         if (state_r == S_SHIFT) begin
            shcnt_r <= shcnt_r - 5'h01;
            shift_step_r <= 1'b1;
         end
         if ((state_r == S_EXEC || state_r == S_SHIFT)
             && state_nxt != S_EXEC && state_nxt != S_SHIFT)
            retire_r <= 1'b1;
      end
   end

   // Instruction port; the request is a registered copy of the next state
   always @(posedge clk) begin
      if (rst) begin
         ibus_addr_r <= {AW{1'b0}};
         ibus_read_r <= 1'b0;
         instr_r <= 32'h00000000;
      end else begin
         ibus_addr_r <= fetch_addr;
         ibus_read_r <= (state_nxt == S_FETCH);
         if (state_r == S_FETCH && fetch_ok)
            instr_r <= ibus_readdata;
      end
   end

   // Data port; a request stands unchanged until the slave takes it
   always @(posedge clk) begin
      if (rst) begin
         dbus_addr_r <= {AW{1'b0}};
         dbus_read_r <= 1'b0;
         dbus_write_r <= 1'b0;
         dbus_writedata_r <= 32'h00000000;
      end else begin
         if (state_r == S_DEC && mem_go) begin
            dbus_addr_r <= {1'b0, data_addr[AW-2:0]};
            dbus_read_r <= is_load;
            dbus_write_r <= !is_load;
            dbus_writedata_r <= data_wdata;
         end
         if (state_r == S_XFER && xfer_ok) begin
            dbus_read_r <= 1'b0;
            dbus_write_r <= 1'b0;
         end
      end
   end

   // Exception flag stands until the next decode; the interrupt outranks the rest
   always @(posedge clk) begin
      if (rst) begin
         exc_r <= 1'b0;
         exc_cause_r <= `ECS_EXC_IRQ;
      end else if (state_r == S_DEC) begin
         exc_r <= 1'b0;
         if (irq) begin
            exc_r <= 1'b1;
            exc_cause_r <= `ECS_EXC_IRQ;
         end else if (op_illegal) begin
            exc_r <= 1'b1;
            exc_cause_r <= `ECS_EXC_ILLEGAL;
         end else if (op_class == `ECS_CLS_TRAP) begin
            exc_r <= 1'b1;
            exc_cause_r <= `ECS_EXC_TRAP;
         end else if (op_class == `ECS_CLS_UNIMP) begin
            exc_r <= 1'b1;
            exc_cause_r <= `ECS_EXC_UNIMP;
         end
      end
   end
endmodule

// ==== ecs_regs.vh ====
`ifndef ECS_REGS_VH
`define ECS_REGS_VH
// Instruction class codes presented on op_class
`define ECS_CLS_ALU      3'h0
`define ECS_CLS_LDW      3'h1
`define ECS_CLS_LDH      3'h2
`define ECS_CLS_LDB      3'h3
`define ECS_CLS_STORE    3'h4
`define ECS_CLS_SHIFT    3'h5
`define ECS_CLS_TRAP     3'h6
`define ECS_CLS_UNIMP    3'h7
// Cycle budgets
`define ECS_CYC_BASE     6'h06
`define ECS_CYC_LDH      6'h09
`define ECS_CYC_LDB      6'h0A
`define ECS_CYC_SHIFT    6'h07
// Exception cause codes
`define ECS_EXC_IRQ      2'h0
`define ECS_EXC_TRAP     2'h1
`define ECS_EXC_ILLEGAL  2'h2
`define ECS_EXC_UNIMP    2'h3
`endif

// ==== ecs_cycle_counter.v ====
`timescale 1ns/100ps
// Counts down a cycle budget; done pulses when the budget is spent.
module ecs_cycle_counter #(
   parameter W = 6
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         load,
   input  wire [W-1:0] count,
   input  wire         run,
   output wire         done
);
   reg [W-1:0] cnt_r;
   reg [W-1:0] cnt_nxt;

   always @* begin
      cnt_nxt = cnt_r;
      if (load)
         cnt_nxt = count;
      else if (run && cnt_r != {W{1'b0}})
         cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
   end

   always @(posedge clk) begin
      if (rst)
         cnt_r <= {W{1'b0}};
      else
         cnt_r <= cnt_nxt;
   end

   assign done = run && !load && (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule

// ==== ecs_bus_model.sv ====
`timescale 1ns/100ps
module ecs_bus_model #(
   parameter IWORD = 32'h1234ABCD
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        ibus_read_r,
   input  wire        dbus_req,
   input  wire [3:0]  iw,
   input  wire [3:0]  dw,
   output wire        ibus_waitrequest,
   output wire        dbus_waitrequest,
   output wire [31:0] ibus_readdata
);
   reg [3:0] icnt_r;
   reg [3:0] dcnt_r;
   // Completion comes after exactly iw or dw stall cycles
   assign ibus_waitrequest = ibus_read_r && (icnt_r != iw);
   assign dbus_waitrequest = dbus_req && (dcnt_r != dw);
   // Outside the accepting cycle the lines show the inverse, so a late capture is seen
   assign ibus_readdata = (ibus_read_r && !ibus_waitrequest) ? IWORD : ~IWORD;
   always @(posedge clk) begin
      icnt_r <= (rst || !ibus_waitrequest) ? 4'h0 : icnt_r + 4'h1;
      dcnt_r <= (rst || !dbus_waitrequest) ? 4'h0 : dcnt_r + 4'h1;
   end
endmodule

// ==== ecs_seq_monitor.sv ====
`timescale 1ns/100ps
module ecs_seq_monitor #(
   parameter AW = 32
) (
   input wire          clk,
   input wire          rst,
   input wire          ibus_read_r,
   input wire          ibus_waitrequest,
   input wire [AW-1:0] dbus_addr_r,
   input wire          dbus_read_r,
   input wire          dbus_write_r,
   input wire          dbus_waitrequest,
   input wire          retire_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence fetch_done;
      ibus_read_r && !ibus_waitrequest;
   endsequence
   sequence data_req;
      dbus_read_r || dbus_write_r;
   endsequence
   AST_ONE_INSTR: assert property (fetch_done |=> !ibus_read_r [*5])
      else $error("fetch overlap");
   AST_BUS_EXCL: assert property (data_req |-> !ibus_read_r)
      else $error("fetch during data transfer");
   AST_MIN_PERIOD: assert property (retire_r |=> !retire_r [*5])
      else $error("retire too soon");
   AST_FETCH_HOLD: assert property (ibus_read_r && ibus_waitrequest |=> ibus_read_r)
      else $error("fetch dropped");
   AST_DATA_HOLD: assert property (data_req ##0 dbus_waitrequest |=>
      $stable({dbus_read_r, dbus_write_r, dbus_addr_r})) else $error("data request moved");
   AST_TOP_BIT: assert property (data_req |-> !dbus_addr_r[AW-1])
      else $error("address top bit set");
   AST_LOAD_END: assert property (dbus_read_r && !dbus_waitrequest |-> ##[1:12] retire_r)
      else $error("load did not retire");
   AST_STORE_END: assert property (dbus_write_r && !dbus_waitrequest |-> ##[1:8] retire_r)
      else $error("store did not retire");
endmodule
bind ecs_sequencer ecs_seq_monitor #(.AW(AW)) u_mon (.clk(clk), .rst(rst),
   .ibus_read_r(ibus_read_r), .ibus_waitrequest(ibus_waitrequest),
   .dbus_addr_r(dbus_addr_r), .dbus_read_r(dbus_read_r), .dbus_write_r(dbus_write_r),
   .dbus_waitrequest(dbus_waitrequest), .retire_r(retire_r));

// ==== ecs_sequencer_test.sv ====
`timescale 1ns/100ps
`include "ecs_regs.vh"
`define CHK(a, b) begin cmp_count = cmp_count + 1; if ((a) !== (b)) begin \
   num_errors = num_errors + 1; $display("MISMATCH %0t check failed", $time); end end
module ecs_sequencer_test;
   localparam IWORD = 32'h1234ABCD;
   reg         clk        = 1'b0;
   reg         rst        = 1'b1;
   reg  [2:0]  op_class   = 3'h0;
   reg  [4:0]  shift_amt  = 5'h00;
   reg  [1:0]  fault      = 2'h0;
   reg         dbg_halt   = 1'b1;
   reg  [3:0]  iw         = 4'h0;
   reg  [3:0]  dw         = 4'h0;
   integer     num_errors = 0;
   integer     cmp_count  = 0;
   wire        ird, iwt, drd, dwt, dwq, exc, ret, hlt, stp;
   wire [1:0]  cause;
   wire [31:0] instr, rdata, iaddr, daddr, wdat;
   ecs_sequencer u_dut (.clk(clk), .rst(rst), .fetch_addr(32'h00000100), .ibus_addr_r(iaddr),
      .ibus_read_r(ird), .ibus_waitrequest(iwt), .ibus_readdata(rdata), .instr_r(instr),
      .op_class(op_class), .shift_amt(shift_amt), .op_illegal(fault[1]), .irq(fault[0]),
      .data_addr(32'hFFFFFFF0), .data_wdata(32'h5A5AA5A5), .dbus_addr_r(daddr),
      .dbus_read_r(drd), .dbus_write_r(dwt), .dbus_writedata_r(wdat), .dbus_waitrequest(dwq),
      .exc_r(exc), .exc_cause_r(cause), .retire_r(ret), .shift_step_r(stp), .dbg_halt(dbg_halt),
      .dbg_halted_r(hlt));
   ecs_bus_model #(.IWORD(IWORD)) u_bus (.clk(clk), .rst(rst), .ibus_read_r(ird),
      .dbus_req(drd | dwt), .iw(iw), .dw(dw), .ibus_waitrequest(iwt),
      .dbus_waitrequest(dwq), .ibus_readdata(rdata));
   initial forever #50 clk = ~clk;
   task finish_test;
      begin
         if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // Halt is held between instructions so each one runs alone with its settings
   task automatic do_op(input [2:0] c, input [4:0] a, input [1:0] x, input [3:0] f,
      input [3:0] d, input integer en, input integer ed, input [2:0] ex);
      integer n;
      integer dn;
      integer sn;
      begin
         n = 0;
         dn = 0;
         sn = 0;
         while (hlt !== 1'b1 && n < 200) begin
            @(negedge clk);
            n = n + 1;
         end
         `CHK(hlt, 1'b1)
         @(posedge clk);
         op_class <= c;
         shift_amt <= a;
         fault <= x;
         iw <= f;
         dw <= d;
         @(posedge clk);
         dbg_halt <= 1'b0;
         n = 0;
         while (ird !== 1'b1 && n < 20) begin
            @(negedge clk);
            n = n + 1;
         end
         `CHK(iaddr, 32'h00000100)
         @(posedge clk);
         dbg_halt <= 1'b1;
         n = 0;
         while (ret !== 1'b1 && n < 60) begin
            @(negedge clk);
            n = n + 1;
            if (drd === 1'b1 || dwt === 1'b1) begin
               dn = dn + 1;
               `CHK(daddr, 32'h7FFFFFF0)
            end
            if (dwt === 1'b1)
               `CHK(wdat, 32'h5A5AA5A5)
            if (stp === 1'b1)
               sn = sn + 1;
         end
         if (en > 0)
            `CHK(n, en)
         `CHK(dn, ed)
         `CHK(sn, (c == `ECS_CLS_SHIFT) ? a : 5'h00)
         `CHK(exc, !ex[2])
         if (!ex[2])
            `CHK(cause, ex[1:0])
         `CHK(instr, IWORD)
      end
   endtask
   task t_timing;
      begin
         do_op(`ECS_CLS_ALU, 5'h1F, 2'h0, 4'h0, 4'h0, 6, 0, 3'h4);
         do_op(`ECS_CLS_ALU, 5'h00, 2'h0, 4'h3, 4'h0, 9, 0, 3'h4);
         do_op(`ECS_CLS_LDW, 5'h00, 2'h0, 4'h0, 4'h0, 7, 1, 3'h4);
         do_op(`ECS_CLS_LDH, 5'h00, 2'h0, 4'h0, 4'h2, 12, 3, 3'h4);
         do_op(`ECS_CLS_LDB, 5'h00, 2'h0, 4'h0, 4'h0, 11, 1, 3'h4);
         do_op(`ECS_CLS_STORE, 5'h00, 2'h0, 4'h0, 4'h1, 8, 2, 3'h4);
         do_op(`ECS_CLS_SHIFT, 5'h00, 2'h0, 4'h0, 4'h0, 7, 0, 3'h4);
         do_op(`ECS_CLS_SHIFT, 5'h1F, 2'h0, 4'h0, 4'h0, 38, 0, 3'h4);
      end
   endtask
   task t_faults;
      begin
         do_op(`ECS_CLS_TRAP, 5'h00, 2'h0, 4'h0, 4'h0, 6, 0, 3'h1);
         do_op(`ECS_CLS_UNIMP, 5'h00, 2'h0, 4'h0, 4'h0, 6, 0, 3'h3);
         do_op(`ECS_CLS_LDW, 5'h00, 2'h1, 4'h0, 4'h0, 0, 0, 3'h0);
         do_op(`ECS_CLS_STORE, 5'h00, 2'h2, 4'h0, 4'h0, 0, 0, 3'h2);
      end
   endtask
   // Mid-run reset from the halted state: outputs clear, then a fetch starts one cycle after release
   task t_reset;
      begin
         @(posedge clk);
         rst <= 1'b1;
         op_class <= `ECS_CLS_ALU;
         iw <= 4'h0;
         @(posedge clk);
         @(negedge clk);
         `CHK({ird, drd, dwt, exc, ret, stp, hlt}, 7'h00)
         `CHK(instr, 32'h00000000)
         @(posedge clk);
         rst <= 1'b0;
         @(negedge clk);
         `CHK(ird, 1'b0)
         @(negedge clk);
         `CHK(ird, 1'b1)
         @(negedge clk);
         `CHK(ird, 1'b0)
         `CHK(instr, IWORD)
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_timing;
      t_reset;
      t_faults;
      finish_test;
   end
   initial begin
      #200000;
      num_errors = num_errors + 1;
      finish_test;
   end
endmodule
